// [rtl/bdsc_pkg.sv]
// Constants, types and helpers of the background debug status/control bank.
// Assumes one clock (ref_clk, 250 MHz) and a synchronous active-low reset.
package bdsc_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BDSC_OFS_SCR = 2'h0;
  localparam logic [1:0] BDSC_OFS_BKPTH = 2'h1;
  localparam logic [1:0] BDSC_OFS_BKPTL = 2'h2;
  localparam logic [1:0] BDSC_OFS_FRST = 2'h3;
  localparam logic [7:0] BDSC_SCR_RESET = 8'h00;
  localparam logic [7:0] BDSC_BKPT_RESET = 8'h00;
  localparam logic [7:0] BDSC_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the status/control register
  // ----------------------------------------------------------------
  localparam int BDSC_BIT_ENBL = 7;
  localparam int BDSC_BIT_ACT = 6;
  localparam int BDSC_BIT_BKEN = 5;
  localparam int BDSC_BIT_FTS = 4;
  localparam int BDSC_BIT_CLKSEL = 3;
  localparam int BDSC_BIT_WS = 2;
  localparam int BDSC_BIT_WSF = 1;
  localparam int BDSC_BIT_DVF = 0;
  // Bit of the force-reset register that requests a system reset
  localparam int BDSC_BIT_FRST = 0;

  // ----------------------------------------------------------------
  // Tag queue geometry (instruction queue depth of the core)
  // ----------------------------------------------------------------
  localparam int BDSC_TAGQ_DEPTH = 2;
  localparam int BDSC_TAGQ_IW = 1;

  // Background mode of the core, Gray along run -> active
  typedef enum logic {
    BDSC_RUN = 1'b0,
    BDSC_BDM = 1'b1
  } bdsc_mode_e;

  // Full 16-bit compare of the address bus against the match bytes
  function automatic logic bdsc_addr_match(input logic [15:0] addr,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    bdsc_addr_match = (addr == {hi, lo});
  endfunction

  // Next queue index with wrap
  function automatic logic [BDSC_TAGQ_IW-1:0] bdsc_inc(
      input logic [BDSC_TAGQ_IW-1:0] idx);
    bdsc_inc = idx + 1'b1;
  endfunction

endpackage

// [rtl/bdsc_tag_if.sv]
// Carrier between the control bank and its opcode tag queue.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
interface bdsc_tag_if;
  logic push;
  logic push_tag;
  logic pop;
  logic flush;
  logic hit;

  modport core (
    output push,
    output push_tag,
    output pop,
    output flush,
    input hit
  );

  modport queue (
    input push,
    input push_tag,
    input pop,
    input flush,
    output hit
  );
endinterface

// [rtl/bdsc_tagq.sv]
// Tag bits that travel alongside opcodes in the core's instruction queue.
// Assumes push on opcode fetch, pop when the head opcode executes, and
// flush on any change of flow; the core never overfills its queue.
`timescale 1ns/10ps
module bdsc_tagq
  import bdsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  bdsc_tag_if.queue tq
);

  logic [BDSC_TAGQ_DEPTH-1:0] tag_q;
  logic [BDSC_TAGQ_IW-1:0] wr_q;
  logic [BDSC_TAGQ_IW-1:0] rd_q;
  logic [BDSC_TAGQ_IW:0] cnt_q;
  logic can_pop;
  logic can_push;
  logic hit_q;

  assign can_pop = tq.pop && (cnt_q != '0);
  assign can_push = tq.push &&
    ((cnt_q != (BDSC_TAGQ_IW+1)'(BDSC_TAGQ_DEPTH)) || can_pop);
  assign tq.hit = hit_q;

  // Tag storage, indexed by the write pointer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tag_q <= '0;
    end else if (can_push) begin
      tag_q[wr_q] <= tq.push_tag;
    end
  end

  // Pointers; a flush throws every queued tag away unseen, except one popped in the same cycle, which still reports its hit
  always_ff @(posedge ref_clk) begin
    if (!nrst || tq.flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (can_push) begin
        wr_q <= bdsc_inc(wr_q);
      end
      if (can_pop) begin
        rd_q <= bdsc_inc(rd_q);
      end
      cnt_q <= cnt_q + (BDSC_TAGQ_IW+1)'(can_push)
                     - (BDSC_TAGQ_IW+1)'(can_pop);
    end
  end

  // Only an executed tagged opcode reports a hit
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= can_pop && tag_q[rd_q];
    end
  end

endmodule

// [rtl/bdsc_top.sv]
// Status, control and breakpoint bank of the background debug controller.
// Assumes a serial command decoder on ref_clk presents decoded register
// commands, and the core reports address bus, fetches and queue events on
// the same clock. Only the background pin comes from outside the domain.
`timescale 1ns/10ps
module bdsc_top
  import bdsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bkgd_pin,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_queue_pop,
  input wire logic cpu_queue_flush,
  input wire logic cpu_instr_boundary,
  input wire logic bgnd_cmd,
  input wire logic go_cmd,
  input wire logic wait_stop,
  input wire logic wait_stop_fail,
  input wire logic data_valid_fail,
  output logic bdm_enabled,
  output logic bdm_active,
  output logic comm_clock_select,
  output logic break_req,
  output logic tag_break,
  output logic swi_req,
  output logic force_reset
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bdsc_mode_e mode_q;
  logic enbl_q;
  logic bken_q;
  logic fts_q;
  logic clksel_q;
  logic ws_q;
  logic wsf_q;
  logic dvf_q;
  logic [7:0] bkpt_hi_q;
  logic [7:0] bkpt_lo_q;
  logic bkgd_s1_q;
  logic bkgd_s2_q;
  logic boot_q;
  logic force_pend_q;
  logic rsp_valid_q;
  logic [7:0] rsp_rdata_q;
  logic tag_break_q;
  logic swi_q;
  logic frst_q;

  logic scr_wr;
  logic hi_wr;
  logic lo_wr;
  logic frst_wr;
  logic match;
  logic force_fire;
  logic entry_req;
  logic brk_src;
  logic boot_bdm;
  logic [7:0] scr_view;

  bdsc_tag_if tag_bus ();

  bdsc_tagq u_tagq (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tq(tag_bus.queue)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // The only write path into this bank is the serial command port; the
  // core's own bus never reaches these registers
  assign scr_wr = cmd_valid && cmd_write && (cmd_addr == BDSC_OFS_SCR);
  assign hi_wr = cmd_valid && cmd_write && (cmd_addr == BDSC_OFS_BKPTH);
  assign lo_wr = cmd_valid && cmd_write && (cmd_addr == BDSC_OFS_BKPTL);
  assign frst_wr = cmd_valid && cmd_write && (cmd_addr == BDSC_OFS_FRST);

  // ----------------------------------------------------------------
  // Breakpoint compare
  // ----------------------------------------------------------------
  // With the breakpoint disabled neither selector nor match bytes have
  // any effect
  assign match = bken_q && cpu_addr_valid &&
                 bdsc_addr_match(cpu_addr, bkpt_hi_q, bkpt_lo_q);

  // Tag mode marks the fetched opcode instead of breaking
  assign tag_bus.push = cpu_opcode_fetch;
  assign tag_bus.push_tag = match && !fts_q && cpu_opcode_fetch;
  assign tag_bus.pop = cpu_queue_pop;
  assign tag_bus.flush = cpu_queue_flush;

  // A pending force break acts at the next instruction boundary
  assign force_fire = force_pend_q && cpu_instr_boundary;
  // Breakpoint sources, as opposed to the host's background command
  assign brk_src = tag_bus.hit || force_fire;
  assign entry_req = bgnd_cmd || brk_src;

  // Strap level seen in the first cycle after reset release
  assign boot_bdm = boot_q && !bkgd_s2_q;

  // ----------------------------------------------------------------
  // Background pin synchroniser and boot capture
  // ----------------------------------------------------------------
  // Two flops before use; the pin is asynchronous to ref_clk. They keep
  // sampling under reset, so the strap level is settled at release.
  always_ff @(posedge ref_clk) begin
    bkgd_s1_q <= bkgd_pin;
    bkgd_s2_q <= bkgd_s1_q;
  end

  // Marks the first cycle after release, when the strap is sampled.
  // A constant reset avoids loading a pin level under reset.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Background enable
  // ----------------------------------------------------------------
  // Write-one sets; writing zero cannot clear, only normal reset does
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      enbl_q <= BDSC_SCR_RESET[BDSC_BIT_ENBL];
    end else if (boot_bdm) begin
      enbl_q <= 1'b1;
    end else if (scr_wr && cmd_wdata[BDSC_BIT_ENBL]) begin
      enbl_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Background mode
  // ----------------------------------------------------------------
  // Entry is refused while the enable is clear; other commands are not
  // affected by this, they never look at the enable
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= BDSC_RUN;
    end else if (boot_bdm) begin
      mode_q <= BDSC_BDM;
    end else begin
      unique case (mode_q)
        BDSC_RUN: begin
          // The enable must already be set when the request arrives
          if (entry_req && enbl_q) begin
            mode_q <= BDSC_BDM;
          end
        end
        BDSC_BDM: begin
          if (go_cmd) begin
            mode_q <= BDSC_RUN;
          end
        end
      endcase
    end
  end

  // A breakpoint with background mode not enabled becomes a software
  // interrupt request instead, one pulse per refused break
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      swi_q <= 1'b0;
    end else begin
      swi_q <= (mode_q == BDSC_RUN) && brk_src && !enbl_q;
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // Breakpoint enable and selector; both zero after any reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bken_q <= BDSC_SCR_RESET[BDSC_BIT_BKEN];
      fts_q <= BDSC_SCR_RESET[BDSC_BIT_FTS];
    end else if (scr_wr) begin
      bken_q <= cmd_wdata[BDSC_BIT_BKEN];
      fts_q <= cmd_wdata[BDSC_BIT_FTS];
    end
  end

  // Clock select: zero picks the alternate clock, one the bus clock
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      clksel_q <= BDSC_SCR_RESET[BDSC_BIT_CLKSEL];
    end else if (boot_bdm) begin
      clksel_q <= 1'b1;
    end else if (scr_wr) begin
      clksel_q <= cmd_wdata[BDSC_BIT_CLKSEL];
    end
  end

  // ----------------------------------------------------------------
  // Low status bits
  // ----------------------------------------------------------------
  // Failure flags are sticky; a control write clears them, but a new
  // failure in the same cycle wins so no event is lost
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ws_q <= BDSC_SCR_RESET[BDSC_BIT_WS];
      wsf_q <= BDSC_SCR_RESET[BDSC_BIT_WSF];
      dvf_q <= BDSC_SCR_RESET[BDSC_BIT_DVF];
    end else begin
      ws_q <= wait_stop;
      wsf_q <= wait_stop_fail || (wsf_q && !scr_wr);
      dvf_q <= data_valid_fail || (dvf_q && !scr_wr);
    end
  end

  // ----------------------------------------------------------------
  // Breakpoint match address
  // ----------------------------------------------------------------
  // High byte at offset 1, low byte at offset 2, both reset to zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bkpt_hi_q <= BDSC_BKPT_RESET;
      bkpt_lo_q <= BDSC_BKPT_RESET;
    end else begin
      if (hi_wr) begin
        bkpt_hi_q <= cmd_wdata;
      end
      if (lo_wr) begin
        bkpt_lo_q <= cmd_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Force breakpoint
  // ----------------------------------------------------------------
  // A match in force mode is held until the current instruction ends;
  // a new match on that same boundary re-arms it. Disabling the
  // breakpoint drops a pending request.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      force_pend_q <= 1'b0;
    end else if (!bken_q) begin
      force_pend_q <= 1'b0;
    end else if (match && fts_q) begin
      force_pend_q <= 1'b1;
    end else if (cpu_instr_boundary) begin
      force_pend_q <= 1'b0;
    end
  end

  // Tag hit reported to the core, one pulse per executed tagged opcode
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tag_break_q <= 1'b0;
    end else begin
      tag_break_q <= tag_bus.hit;
    end
  end

  // ----------------------------------------------------------------
  // Force-reset register
  // ----------------------------------------------------------------
  // One-cycle system reset request; nothing is stored to read back
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      frst_q <= 1'b0;
    end else begin
      frst_q <= frst_wr && cmd_wdata[BDSC_BIT_FRST];
    end
  end

  // ----------------------------------------------------------------
  // Read response
  // ----------------------------------------------------------------
  // Active bit is pure status from the mode; host writes to it are lost
  always_comb begin
    scr_view = BDSC_SCR_RESET;
    scr_view[BDSC_BIT_ENBL] = enbl_q;
    scr_view[BDSC_BIT_ACT] = (mode_q == BDSC_BDM);
    scr_view[BDSC_BIT_BKEN] = bken_q;
    scr_view[BDSC_BIT_FTS] = fts_q;
    scr_view[BDSC_BIT_CLKSEL] = clksel_q;
    scr_view[BDSC_BIT_WS] = ws_q;
    scr_view[BDSC_BIT_WSF] = wsf_q;
    scr_view[BDSC_BIT_DVF] = dvf_q;
  end

  // Every command, read or write, gets a one-cycle answer next cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= BDSC_READ_ZERO;
    end else begin
      rsp_valid_q <= cmd_valid;
      if (cmd_valid && !cmd_write) begin
        unique case (cmd_addr)
          BDSC_OFS_SCR: rsp_rdata_q <= scr_view;
          BDSC_OFS_BKPTH: rsp_rdata_q <= bkpt_hi_q;
          BDSC_OFS_BKPTL: rsp_rdata_q <= bkpt_lo_q;
          BDSC_OFS_FRST: rsp_rdata_q <= BDSC_READ_ZERO;
        endcase
      end else begin
        rsp_rdata_q <= BDSC_READ_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign bdm_enabled = enbl_q;
  assign bdm_active = (mode_q == BDSC_BDM);
  assign comm_clock_select = clksel_q;
  assign break_req = force_pend_q;
  assign tag_break = tag_break_q;
  assign swi_req = swi_q;
  assign force_reset = frst_q;

endmodule

// [verification/bdsc_chk.sv]
// Checker of the debug bank's command port and mode outputs.
// Assumes it is bound to bdsc_top and sees only its ports.
`timescale 1ns/10ps
module bdsc_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic bgnd_cmd,
  input wire logic go_cmd,
  input wire logic bdm_enabled,
  input wire logic bdm_active,
  input wire logic comm_clock_select,
  input wire logic break_req,
  input wire logic tag_break,
  input wire logic force_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ----
  // Command port
  // ----
  property p_rsp;
    cmd_valid |=> rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("missing answer");
  property p_rd0;
    cmd_valid && (cmd_write || cmd_addr == 2'h3) |=> rsp_rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("nonzero data");
  property p_frst;
    cmd_valid && cmd_write && cmd_addr == 2'h3
      |=> force_reset == $past(cmd_wdata[0]);
  endproperty
  a_frst: assert property (p_frst) else $error("force pulse");
  property p_clk;
    $past(nrst) && cmd_valid && cmd_write && cmd_addr == 2'h0
      |=> comm_clock_select == $past(cmd_wdata[3]);
  endproperty
  a_clk: assert property (p_clk) else $error("clock select");
  // ----
  // Background mode
  // ----
  property p_en_set;
    cmd_valid && cmd_write && cmd_addr == 2'h0 && cmd_wdata[7]
      |=> bdm_enabled;
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set");
  // Enable may only drop through reset, which disables this check
  property p_en_hold;
    bdm_enabled |=> bdm_enabled;
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable lost");
  property p_refuse;
    $past(nrst) && bgnd_cmd && !bdm_enabled && !bdm_active |=> !bdm_active;
  endproperty
  a_refuse: assert property (p_refuse) else $error("entry taken");
  property p_enter;
    bgnd_cmd && bdm_enabled && !go_cmd |=> bdm_active;
  endproperty
  a_enter: assert property (p_enter) else $error("entry lost");
  property p_exit;
    go_cmd && !bgnd_cmd |=> !bdm_active;
  endproperty
  a_exit: assert property (p_exit) else $error("exit lost");
  // Boot load into background mode is the one entry without prior enable
  property p_act;
    $rose(bdm_active) |-> $past(bdm_enabled) || !$past(nrst, 2);
  endproperty
  a_act: assert property (p_act) else $error("active early");
  c_enter: cover property (bgnd_cmd && bdm_enabled);
  c_force: cover property (break_req);
  c_tag: cover property (tag_break);
endmodule

bind bdsc_top bdsc_chk i_bdsc_chk (
  .ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bgnd_cmd(bgnd_cmd),
  .go_cmd(go_cmd), .bdm_enabled(bdm_enabled), .bdm_active(bdm_active),
  .comm_clock_select(comm_clock_select), .break_req(break_req),
  .tag_break(tag_break), .force_reset(force_reset)
);

// [verification/bdsc_host.sv]
// Debug host model: issues decoded serial commands to the bank.
// Assumes the bench calls xfer from one process, clocked by ref_clk.
`timescale 1ns/10ps
module bdsc_host (
  input wire logic ref_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [1:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata
);
  // Idle lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 2'h0;
    cmd_wdata = 8'h00;
  end
  // Register access only through commands; held over the taking edge.
  // Released address and data lines show the inverse, so stale data is never reused.
  task automatic xfer(input logic wr, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    cmd_wdata = ~d;
    ok = (rsp_valid === 1'b1);
    q = rsp_rdata;
  endtask
endmodule

// [verification/bdsc_top_tb.sv]
// Self-checking bench of the debug status/control bank.
// Assumes the host model for commands; the core side is driven here.
`timescale 1ns/10ps
module bdsc_top_tb;
  logic ref_clk, nrst, bkgd_pin, cpu_addr_valid, fetch;
  logic pop, flush, bound, go, bgnd;
  logic [15:0] cpu_addr;
  logic cmd_valid, cmd_write, rsp_valid;
  logic [1:0] cmd_addr;
  logic [7:0] cmd_wdata, rsp_rdata, q;
  logic bdm_enabled, bdm_active, clksel, break_req, tag_break;
  logic swi_req, force_reset;
  int n_mismatch, total_checks;
  // Rows: write, offset, data, expected answer
  logic [18:0] rows [0:15] = '{
    {1'b0, 2'h0, 8'h00, 8'h00}, {1'b0, 2'h1, 8'h00, 8'h00},
    {1'b0, 2'h2, 8'h00, 8'h00}, {1'b0, 2'h3, 8'h00, 8'h00},
    {1'b1, 2'h1, 8'hA5, 8'h00}, {1'b0, 2'h1, 8'h00, 8'hA5},
    {1'b1, 2'h2, 8'h3C, 8'h00}, {1'b0, 2'h2, 8'h00, 8'h3C},
    {1'b1, 2'h3, 8'hFE, 8'h00}, {1'b0, 2'h3, 8'h00, 8'h00},
    {1'b1, 2'h0, 8'h4F, 8'h00}, {1'b0, 2'h0, 8'h00, 8'h08},
    {1'b1, 2'h0, 8'h80, 8'h00}, {1'b0, 2'h0, 8'h00, 8'h80},
    {1'b1, 2'h0, 8'h00, 8'h00}, {1'b0, 2'h0, 8'h00, 8'h80}};

  bdsc_top i_bdsc_top (
    .ref_clk(ref_clk), .nrst(nrst), .bkgd_pin(bkgd_pin),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
    .cpu_opcode_fetch(fetch), .cpu_queue_pop(pop),
    .cpu_queue_flush(flush), .cpu_instr_boundary(bound),
    .bgnd_cmd(bgnd), .go_cmd(go), .wait_stop(1'b0),
    .wait_stop_fail(1'b0), .data_valid_fail(1'b0),
    .bdm_enabled(bdm_enabled), .bdm_active(bdm_active),
    .comm_clock_select(clksel), .break_req(break_req),
    .tag_break(tag_break), .swi_req(swi_req), .force_reset(force_reset));
  bdsc_host i_bdsc_host (
    .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  // ----
  // Shared tasks
  // ----
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  // A missing answer ends the run, since later steps would be noise
  task automatic cmd(input logic wr, input logic [1:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    logic ok;
    i_bdsc_host.xfer(wr, a, d, r, ok);
    chk1(ok, 1'b1);
    if (ok !== 1'b1) begin
      summarize;
    end
  endtask
  task automatic rst(input logic pin);
    @(negedge ref_clk);
    nrst = 1'b0;
    bkgd_pin = pin;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  // One-cycle pulse: 0 bgnd, 1 go, 2 boundary, 3 pop, 4 flush
  task automatic strobe(input int k);
    @(negedge ref_clk);
    {flush, pop, bound, go, bgnd} = 5'(1 << k);
    @(negedge ref_clk);
    {flush, pop, bound, go, bgnd} = 5'h00;
  endtask
  // One bus cycle at the match address, optionally an opcode fetch
  task automatic hit(input logic f);
    @(negedge ref_clk);
    cpu_addr = 16'h1234;
    cpu_addr_valid = 1'b1;
    fetch = f;
    @(negedge ref_clk);
    cpu_addr = 16'hEDCB;
    cpu_addr_valid = 1'b0;
    fetch = 1'b0;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    bkgd_pin = 1'b1;
    cpu_addr = 16'h0000;
    cpu_addr_valid = 1'b0;
    fetch = 1'b0;
    {flush, pop, bound, go, bgnd} = 5'h00;
    rst(1'b1);
    for (int i = 0; i < 16; i++) begin
      cmd(rows[i][18], rows[i][17:16], rows[i][15:8], q);
      chk8(q, rows[i][7:0]);
    end
    cmd(1'b1, 2'h3, 8'h01, q);
    chk1(force_reset, 1'b1);
    strobe(0);
    chk1(bdm_active, 1'b1);
    cmd(1'b0, 2'h0, 8'h00, q);
    chk8(q, 8'hC0);
    strobe(1);
    chk1(bdm_active, 1'b0);
    // Force breakpoint waits for the instruction boundary
    cmd(1'b1, 2'h1, 8'h12, q);
    cmd(1'b1, 2'h2, 8'h34, q);
    cmd(1'b1, 2'h0, 8'hB0, q);
    hit(1'b0);
    chk1(break_req, 1'b1);
    strobe(2);
    chk1(break_req, 1'b0);
    chk1(bdm_active, 1'b1);
    strobe(1);
    cmd(1'b1, 2'h0, 8'h90, q);
    hit(1'b0);
    chk1(break_req, 1'b0);
    // Tagged opcode: discarded first, then executed
    cmd(1'b1, 2'h0, 8'hA0, q);
    hit(1'b1);
    chk1(break_req, 1'b0);
    strobe(4);
    strobe(3);
    @(negedge ref_clk);
    chk1(tag_break, 1'b0);
    chk1(bdm_active, 1'b0);
    hit(1'b1);
    strobe(3);
    @(negedge ref_clk);
    chk1(tag_break, 1'b1);
    chk1(bdm_active, 1'b1);
    strobe(1);
    // Reset into background mode, then a normal reset
    rst(1'b0);
    chk1(bdm_enabled & bdm_active & clksel, 1'b1);
    cmd(1'b0, 2'h0, 8'h00, q);
    chk8(q, 8'hC8);
    rst(1'b1);
    chk1(bdm_enabled, 1'b0);
    strobe(0);
    chk1(bdm_active, 1'b0);
    cmd(1'b1, 2'h0, 8'h30, q);
    cmd(1'b0, 2'h0, 8'h00, q);
    chk8(q, 8'h30);
    // Force break with the enable clear becomes a software interrupt
    cmd(1'b1, 2'h1, 8'h12, q);
    cmd(1'b1, 2'h2, 8'h34, q);
    hit(1'b0);
    strobe(2);
    chk1(swi_req, 1'b1);
    chk1(bdm_active, 1'b0);
    summarize;
  end
endmodule
